// ---- common/adc_mux_pkg.sv ----
// Purpose: constants and carriers for the converter input control block
// Assumes: 8-bit special function register access on the system clock
// Notes:   offsets other than the pairing register are arbitrary placements
package adc_mux_pkg;

	// ----------------------------------------
	// register offsets
	// ----------------------------------------
	localparam logic [7:0] INPUT_PAIR_CONFIG_ADDR = 8'hba;
	localparam logic [7:0] CHANNEL_SELECT_ADDR    = 8'hbb;
	localparam logic [7:0] PORT_PIN_SELECT_ADDR   = 8'hbd;
	localparam logic [7:0] CONVERTER_CONTROL_ADDR = 8'he8;
	localparam logic [7:0] CONVERTER_CONFIG_ADDR  = 8'hbc;

	// ----------------------------------------
	// field positions and reset values
	// ----------------------------------------
	localparam int          LOWER_PAIR_DIFF_POS = 0;
	localparam int          UPPER_PAIR_DIFF_POS = 1;
	localparam int          HV_TWOS_COMP_POS    = 2;
	localparam int          PORT_PAIR_DIFF_POS  = 3;
	localparam int          ENABLE_POS          = 7;
	localparam int          START_POS           = 4;
	localparam int          BUSY_POS            = 5;
	localparam logic [3:0]  PAIR_CONFIG_MASK    = 4'hf;
	localparam logic [7:0]  PAIR_CONFIG_RESET   = 8'h00;
	localparam logic [3:0]  CHANNEL_RESET       = 4'h0;
	localparam logic [7:0]  PORT_PIN_RESET      = 8'h00;
	localparam logic [2:0]  GAIN_UNITY          = 3'h6;
	localparam int          NUM_CHANNELS        = 9;
	localparam int          RESULT_BITS         = 12;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int          CLK_MHZ         = 100;
	localparam int          SAMPLE_RATE_KSPS = 100;
	localparam int          CONV_CYCLES     = (CLK_MHZ * 1000) / SAMPLE_RATE_KSPS;
	localparam logic [9:0]  CONV_LAST       = 10'(CONV_CYCLES - 1);

	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef struct packed {
		logic       port_diff;
		logic       hv_twos;
		logic       upper_diff;
		logic       lower_diff;
		logic [2:0] gain;
		logic [3:0] channel;
	} conv_setup_t;

	typedef enum logic [1:0] {
		CONV_OFF  = 2'b00,
		CONV_IDLE = 2'b01,
		CONV_RUN  = 2'b11
	} conv_state_t;

endpackage : adc_mux_pkg

// ---- core/setup_latch.sv ----
// Purpose: holds the setup used by the conversion in progress
// Assumes: load is a one-cycle pulse at conversion start
// Notes:   isolates running conversions from channel, pairing and gain register writes
module setup_latch
	import adc_mux_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	input  wire logic        load_i,
	input  wire conv_setup_t setup_i,
	output conv_setup_t      setup_o
);
	conv_setup_t held;
	conv_setup_t next_held;

	always_comb begin
		next_held = held;
		if (load_i) begin
			next_held = setup_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			held <= '{default: 1'b0, gain: GAIN_UNITY};
		end else begin
			held <= next_held;
		end
	end

	assign setup_o = held;

endmodule : setup_latch

// ---- core/adc_input_mux_config.sv ----
// Purpose: enable, input pairing, gain and channel control of the converter input side
// Assumes: byte-wide register port on the system clock, synchronous reset
// Notes:   analog switching is shown as control outputs only
//
// Summary of operation
// - subsystem runs only while converter enable bit is set, else shutdown
// - nine-channel mux feeding a 12-bit converter up to 100 ksps
// - all mux pairs single-ended after reset
// - three-bit gain field selects 0.5, 1, 2, 4, 8 or 16
// - gain is unity after reset
// - pairing register upper four bits read zero, writes ignored
// - bit 3 pairs port-pin even (+) and odd (-) channels
// - bit 2 gives two's complement high-voltage amplifier results
// - bit 1 pairs inputs two (+) and three (-)
// - bit 0 pairs inputs zero (+) and one (-)
// - differential channel results come out in two's complement
// - any combination of eight port pins may be enabled
// - even pins feed one mux input, odd pins another
// - channel select holds four-bit address, upper bits read zero
// - one enable bit per port pin connects it to the mux
module adc_input_mux_config
	import adc_mux_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	input  wire logic        reg_wr_i,
	input  wire logic        reg_rd_i,
	input  wire logic [7:0]  reg_addr_i,
	input  wire logic [7:0]  reg_wdata_i,
	output logic      [7:0]  reg_rdata_o,
	output logic             subsystem_on_o,
	output logic             converting_o,
	output logic             conv_done_o,
	output logic      [3:0]  mux_select_o,
	output logic      [2:0]  gain_select_o,
	output logic             diff_mode_o,
	output logic             twos_comp_o,
	output logic      [7:0]  pin_connect_o,
	output logic      [3:0]  even_pin_route_o,
	output logic      [3:0]  odd_pin_route_o
);
	// ----------------------------------------
	// registers
	// ----------------------------------------
	logic [3:0] pair_cfg;
	logic [3:0] next_pair_cfg;
	logic [3:0] chan_sel;
	logic [3:0] next_chan_sel;
	logic [7:0] pin_sel;
	logic [7:0] next_pin_sel;
	logic [2:0] gain;
	logic [2:0] next_gain;
	logic       enable;
	logic       next_enable;
	logic       start_req;

	always_comb begin
		next_pair_cfg = pair_cfg;
		next_chan_sel = chan_sel;
		next_pin_sel  = pin_sel;
		next_gain     = gain;
		next_enable   = enable;
		start_req     = 1'b0;
		if (reg_wr_i) begin
			case (reg_addr_i)
				INPUT_PAIR_CONFIG_ADDR: next_pair_cfg = reg_wdata_i[3:0] & PAIR_CONFIG_MASK;
				CHANNEL_SELECT_ADDR:    next_chan_sel = reg_wdata_i[3:0];
				PORT_PIN_SELECT_ADDR:   next_pin_sel  = reg_wdata_i;
				CONVERTER_CONFIG_ADDR:  next_gain     = reg_wdata_i[2:0];
				CONVERTER_CONTROL_ADDR: begin
					next_enable = reg_wdata_i[ENABLE_POS];
					start_req   = reg_wdata_i[START_POS];
				end
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			pair_cfg <= PAIR_CONFIG_RESET[3:0];
			chan_sel <= CHANNEL_RESET;
			pin_sel  <= PORT_PIN_RESET;
			gain     <= GAIN_UNITY;
			enable   <= 1'b0;
		end else begin
			pair_cfg <= next_pair_cfg;
			chan_sel <= next_chan_sel;
			pin_sel  <= next_pin_sel;
			gain     <= next_gain;
			enable   <= next_enable;
		end
	end

	// ----------------------------------------
	// conversion sequencer
	// ----------------------------------------
	conv_state_t state;
	conv_state_t next_state;
	logic [9:0]  cnt;
	logic [9:0]  next_cnt;
	logic        load;
	logic        done;
	conv_setup_t live;
	conv_setup_t used;

	assign live = '{port_diff: pair_cfg[PORT_PAIR_DIFF_POS], hv_twos: pair_cfg[HV_TWOS_COMP_POS],
		upper_diff: pair_cfg[UPPER_PAIR_DIFF_POS], lower_diff: pair_cfg[LOWER_PAIR_DIFF_POS],
		gain: gain, channel: chan_sel};

	always_comb begin
		next_state = state;
		next_cnt   = cnt;
		load       = 1'b0;
		done       = 1'b0;
		case (state)
			CONV_OFF: begin
				if (enable) next_state = CONV_IDLE;
			end
			CONV_IDLE: begin
				if (!enable) begin
					next_state = CONV_OFF;
				end else if (start_req) begin
					load       = 1'b1;
					next_cnt   = CONV_LAST;
					next_state = CONV_RUN;
				end
			end
			CONV_RUN: begin
				if (!enable) begin
					next_state = CONV_OFF;
				end else if (cnt == 10'h000) begin
					done       = 1'b1;
					next_state = CONV_IDLE;
				end else begin
					next_cnt = cnt - 10'h001;
				end
			end
			default: next_state = CONV_OFF;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			state <= CONV_OFF;
			cnt   <= 10'h000;
		end else begin
			state <= next_state;
			cnt   <= next_cnt;
		end
	end

	setup_latch u_setup_latch (
		.clk_i   (clk_i),
		.rst_n_i (rst_n_i),
		.load_i  (load),
		.setup_i (live),
		.setup_o (used)
	);

	// ----------------------------------------
	// routing decode: mux, gain and format from the latched setup, pin routes from the live pin select
	// ----------------------------------------
	logic diff_now;

	always_comb begin
		diff_now = 1'b0;
		case (used.channel)
			4'h0, 4'h1: diff_now = used.lower_diff;
			4'h2, 4'h3: diff_now = used.upper_diff;
			4'h4:       diff_now = used.hv_twos;
			4'h6, 4'h7: diff_now = used.port_diff;
			default:    diff_now = 1'b0;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			reg_rdata_o      <= 8'h00;
			mux_select_o     <= CHANNEL_RESET;
			gain_select_o    <= GAIN_UNITY;
			diff_mode_o      <= 1'b0;
			twos_comp_o      <= 1'b0;
			pin_connect_o    <= 8'h00;
			even_pin_route_o <= 4'h0;
			odd_pin_route_o  <= 4'h0;
		end else begin
			mux_select_o     <= used.channel;
			gain_select_o    <= used.gain;
			diff_mode_o      <= diff_now;
			twos_comp_o      <= diff_now;
			pin_connect_o    <= pin_sel;
			even_pin_route_o <= {pin_sel[6], pin_sel[4], pin_sel[2], pin_sel[0]};
			odd_pin_route_o  <= {pin_sel[7], pin_sel[5], pin_sel[3], pin_sel[1]};
			reg_rdata_o      <= 8'h00;
			if (reg_rd_i) begin
				case (reg_addr_i)
					INPUT_PAIR_CONFIG_ADDR: reg_rdata_o <= {4'h0, pair_cfg};
					CHANNEL_SELECT_ADDR:    reg_rdata_o <= {4'h0, chan_sel};
					PORT_PIN_SELECT_ADDR:   reg_rdata_o <= pin_sel;
					CONVERTER_CONFIG_ADDR:  reg_rdata_o <= {5'h00, gain};
					CONVERTER_CONTROL_ADDR: reg_rdata_o <= {enable, 1'b0, state == CONV_RUN, 5'h00};
					default:                reg_rdata_o <= 8'h00;
				endcase
			end
		end
	end

	assign subsystem_on_o = (state != CONV_OFF);
	assign converting_o   = (state == CONV_RUN);
	assign conv_done_o    = done;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	property p_off_when_disabled;
		@(posedge clk_i) disable iff (!rst_n_i) !enable |=> !subsystem_on_o;
	endproperty
	a_off_when_disabled: assert property (p_off_when_disabled) else $error("on while disabled");

	property p_pair_upper_zero;
		@(posedge clk_i) disable iff (!rst_n_i)
			reg_rd_i && reg_addr_i == INPUT_PAIR_CONFIG_ADDR |=> reg_rdata_o[7:4] == 4'h0;
	endproperty
	a_pair_upper_zero: assert property (p_pair_upper_zero) else $error("pair upper bits set");

	property p_chan_upper_zero;
		@(posedge clk_i) disable iff (!rst_n_i)
			reg_rd_i && reg_addr_i == CHANNEL_SELECT_ADDR |=> reg_rdata_o[7:4] == 4'h0;
	endproperty
	a_chan_upper_zero: assert property (p_chan_upper_zero) else $error("chan upper bits set");

	property p_hold_setup;
		@(posedge clk_i) disable iff (!rst_n_i) converting_o && $past(converting_o) |-> $stable(used);
	endproperty
	a_hold_setup: assert property (p_hold_setup) else $error("setup changed mid conversion");

	property p_conv_len;
		// a disable may legally cut a conversion short, so it ends the attempt
		@(posedge clk_i) disable iff (!rst_n_i || !enable) load && enable |=> converting_o [*8];
	endproperty
	a_conv_len: assert property (p_conv_len) else $error("conversion ended early");

	property p_twos_diff;
		@(posedge clk_i) disable iff (!rst_n_i) 1'b1 |=> twos_comp_o == $past(diff_now);
	endproperty
	a_twos_diff: assert property (p_twos_diff) else $error("format mismatch");

	property p_even_route;
		@(posedge clk_i) disable iff (!rst_n_i) 1'b1 |=> even_pin_route_o[0] == $past(pin_sel[0]);
	endproperty
	a_even_route: assert property (p_even_route) else $error("even route wrong");

	property p_pair_write;
		@(posedge clk_i) disable iff (!rst_n_i)
			reg_wr_i && reg_addr_i == INPUT_PAIR_CONFIG_ADDR |=> pair_cfg == $past(reg_wdata_i[3:0]);
	endproperty
	a_pair_write: assert property (p_pair_write) else $error("pair write lost");

	c_conv_done: cover property (@(posedge clk_i) disable iff (!rst_n_i) done);
	c_diff_conv: cover property (@(posedge clk_i) disable iff (!rst_n_i) load && live.lower_diff);
	c_shutdown:  cover property (@(posedge clk_i) disable iff (!rst_n_i) converting_o ##1 !enable);

endmodule : adc_input_mux_config

// ---- tb/adc_input_mux_config_tb.sv ----
// Purpose: self-checking bench for the converter input control block
// Assumes: register strobes driven 1 ns after the rising edge
// Notes:   assertions live in the design files; this bench only judges ports
module adc_input_mux_config_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import adc_mux_pkg::*;

	// ----------------------------------------
	// clock, reset, design
	// ----------------------------------------
	logic       clk_i = 1'b0;
	logic       rst_n_i = 1'b0;
	logic       reg_wr_i = 1'b0;
	logic       reg_rd_i = 1'b0;
	logic [7:0] reg_addr_i = 8'h00;
	logic [7:0] reg_wdata_i = 8'h00;
	logic [7:0] reg_rdata_o;
	logic       subsystem_on_o, converting_o, conv_done_o, diff_mode_o, twos_comp_o;
	logic [3:0] mux_select_o, even_pin_route_o, odd_pin_route_o;
	logic [2:0] gain_select_o;
	logic [7:0] pin_connect_o;
	int         mismatches = 0;
	int         n_tests = 0;

	always #5 clk_i = ~clk_i;

	adc_input_mux_config i_adc_input_mux_config (.clk_i(clk_i), .rst_n_i(rst_n_i),
		.reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
		.subsystem_on_o(subsystem_on_o), .converting_o(converting_o),
		.conv_done_o(conv_done_o), .mux_select_o(mux_select_o),
		.gain_select_o(gain_select_o), .diff_mode_o(diff_mode_o),
		.twos_comp_o(twos_comp_o), .pin_connect_o(pin_connect_o),
		.even_pin_route_o(even_pin_route_o), .odd_pin_route_o(odd_pin_route_o));

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic step(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask : step

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		step(1);
		reg_wr_i = 1'b1;
		reg_addr_i = a;
		reg_wdata_i = d;
		step(1);
		reg_wr_i = 1'b0;
	endtask : wr

	task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
		step(1);
		reg_rd_i = 1'b1;
		reg_addr_i = a;
		step(1);
		reg_rd_i = 1'b0;
		check(reg_rdata_o, exp);
	endtask : rchk

	task automatic setup(input logic [3:0] ch, input logic [3:0] pr, input logic [2:0] g);
		wr(CHANNEL_SELECT_ADDR, {4'h0, ch});
		wr(INPUT_PAIR_CONFIG_ADDR, {4'h0, pr});
		wr(CONVERTER_CONFIG_ADDR, {5'h00, g});
	endtask : setup

	// bounded wait; a stuck converter shows as a count at the limit
	task automatic wait_done();
		int n;
		n = 0;
		while (conv_done_o !== 1'b1 && n < CONV_CYCLES + 20) begin
			step(1);
			n++;
		end
		check(8'(n < CONV_CYCLES + 20), 8'h01);
	endtask : wait_done

	task automatic judge(input logic [3:0] ch, input logic [3:0] pr, input logic [2:0] g);
		logic d;
		d = (ch < 4'h2) ? pr[0] : (ch < 4'h4) ? pr[1] : (ch == 4'h4) ? pr[2] :
			(ch == 4'h6 || ch == 4'h7) ? pr[3] : 1'b0;
		check(8'(mux_select_o), 8'(ch));
		check(8'(gain_select_o), 8'(g));
		check(8'(diff_mode_o), 8'(d));
		check(8'(twos_comp_o), 8'(d));
	endtask : judge

	task automatic run_conv(input logic [3:0] ch, input logic [3:0] pr, input logic [2:0] g);
		setup(ch, pr, g);
		wr(CONVERTER_CONTROL_ADDR, 8'h90);
		wait_done();
		judge(ch, pr, g);
		step(1);
		check(8'(conv_done_o), 8'h00);
	endtask : run_conv

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset();
		check(8'(subsystem_on_o), 8'h00);
		check(8'(gain_select_o), 8'(GAIN_UNITY));
		check(8'(diff_mode_o), 8'h00);
		rchk(INPUT_PAIR_CONFIG_ADDR, PAIR_CONFIG_RESET);
		rchk(CHANNEL_SELECT_ADDR, 8'h00);
		rchk(PORT_PIN_SELECT_ADDR, PORT_PIN_RESET);
		rchk(CONVERTER_CONFIG_ADDR, 8'(GAIN_UNITY));
		$display("test reset done");
	endtask : t_reset

	task automatic t_regs();
		wr(INPUT_PAIR_CONFIG_ADDR, 8'hff);
		rchk(INPUT_PAIR_CONFIG_ADDR, 8'h0f);
		wr(CHANNEL_SELECT_ADDR, 8'hf5);
		rchk(CHANNEL_SELECT_ADDR, 8'h05);
		wr(PORT_PIN_SELECT_ADDR, 8'ha5);
		rchk(PORT_PIN_SELECT_ADDR, 8'ha5);
		check(pin_connect_o, 8'ha5);
		check(8'(even_pin_route_o), 8'h03);
		check(8'(odd_pin_route_o), 8'h0c);
		rchk(8'h33, 8'h00);
		wr(PORT_PIN_SELECT_ADDR, 8'hff);
		step(2);
		check({even_pin_route_o, odd_pin_route_o}, 8'hff);
		$display("test registers done");
	endtask : t_regs

	task automatic t_enable();
		int p;
		wr(CONVERTER_CONTROL_ADDR, 8'h10);
		step(2);
		check(8'({subsystem_on_o, converting_o}), 8'h00);
		wr(CONVERTER_CONTROL_ADDR, 8'h80);
		step(1);
		check(8'(subsystem_on_o), 8'h01);
		rchk(CONVERTER_CONTROL_ADDR, 8'h80);
		wr(CONVERTER_CONTROL_ADDR, 8'h90);
		step(2);
		check(8'(converting_o), 8'h01);
		rchk(CONVERTER_CONTROL_ADDR, 8'ha0);
		wr(CONVERTER_CONTROL_ADDR, 8'h00);
		step(2);
		check(8'({subsystem_on_o, converting_o}), 8'h00);
		rchk(CONVERTER_CONTROL_ADDR, 8'h00);
		p = 0;
		repeat (CONV_CYCLES + 10) begin
			step(1);
			p += int'(conv_done_o === 1'b1);
		end
		check(8'(p), 8'h00);
		$display("test enable done");
	endtask : t_enable

	task automatic t_pairs();
		logic [10:0] tbl [8] = '{{4'h0, 4'h1, 3'h0}, {4'h1, 4'h1, 3'h1}, {4'h3, 4'h2, 3'h2},
			{4'h4, 4'h4, 3'h3}, {4'h6, 4'h8, 3'h4}, {4'h7, 4'h7, 3'h6}, {4'h5, 4'hf, 3'h2},
			{4'h8, 4'hf, 3'h5}};
		wr(CONVERTER_CONTROL_ADDR, 8'h80);
		foreach (tbl[i]) begin
			run_conv(tbl[i][10:7], tbl[i][6:3], tbl[i][2:0]);
		end
		$display("test pairing done");
	endtask : t_pairs

	// config written mid-run must not reach the running conversion
	task automatic t_hold();
		setup(4'h2, 4'h2, 3'h5);
		wr(CONVERTER_CONTROL_ADDR, 8'h90);
		step(4);
		setup(4'h0, 4'h0, 3'h1);
		judge(4'h2, 4'h2, 3'h5);
		wait_done();
		step(2);
		judge(4'h2, 4'h2, 3'h5);
		run_conv(4'h0, 4'h0, 3'h1);
		$display("test hold done");
	endtask : t_hold

	// ----------------------------------------
	// sequence and verdict
	// ----------------------------------------
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : complete_run

	initial begin
		step(12);
		rst_n_i = 1'b1;
		t_reset();
		t_regs();
		t_enable();
		t_pairs();
		t_hold();
		complete_run();
	end

	initial begin
		#250000;
		mismatches++;
		complete_run();
	end
endmodule : adc_input_mux_config_tb
